//--- alr_comparator.sv
// alarm setpoint comparator with deadband, latching and avalon registers
`timescale 1ns/1ps
module alr_comparator
    import alr_pkg::*;
#(
    parameter int RD_W = 14
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // measured reading from the converter path
    input  wire logic              rd_valid,
    input  wire logic [RD_W-1:0]   rd_data,
    // panel switches and clear contact pins
    input  wire alr_switch_t       sw_pins,
    // alarm outputs
    output logic                   alarm_relay,
    output logic                   alarm_led,
    // avalon-mm slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic [31:0]       avs_writedata,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest
);

    // synchronised switches and decoded setpoint
    alr_switch_t sw;
    alr_val_t    sp;
    logic        sp_on;
    logic [3:0]  db;

    alr_sync #(
        .W          (SW_W)
    ) u_sync (
        .clk        (clk),
        .rst        (rst),
        .pin_raw    (sw_pins),
        .pin_stable (sw)
    );

    alr_setpoint u_setp (
        .clk        (clk),
        .rst        (rst),
        .sw         (sw),
        .sp_value   (sp),
        .sp_on      (sp_on),
        .deadband   (db)
    );

    // state
    logic        alarm_reg;
    logic        alarm_next;
    logic        relay_reg;
    logic        led_reg;
    logic        en_reg;
    logic        clr_reg;
    alr_val_t    last_reg;
    logic [31:0] rdata_reg;
    logic        wait_reg;

    // comparison terms
    alr_val_t rd;
    alr_val_t ret_lim;
    wire      dir_hi;
    wire      latched;
    wire      xclr;
    wire      trip;
    wire      hold;
    wire      upd;

    assign rd      = alr_val_t'(signed'(rd_data));
    assign dir_hi  = (sw.trip_direction_switch == RISING_TRIP_DIRECTION);
    assign latched = (sw.reset_policy_switch == LATCHED_POLICY);
    assign xclr    = sw.external_clear_terminals;
    assign upd     = rd_valid;

    // trip test; equality trips both ways
    assign trip = sp_on && en_reg && (dir_hi ? (rd >= sp)
                                             : (rd <= sp));
    // return limit moves back by the deadband
    assign ret_lim = dir_hi ? sp - alr_widen(db)
                            : sp + alr_widen(db);
    assign hold = dir_hi ? (rd >= ret_lim) : (rd <= ret_lim);

    // alarm next state; clear contact and disable win, trip beats a clear
    always_comb begin
        alarm_next = alarm_reg;
        if (xclr || !sp_on || !en_reg) begin
            alarm_next = 1'b0;
        end else if (upd && trip) begin
            alarm_next = 1'b1;
        end else if (clr_reg && latched) begin
            alarm_next = 1'b0;
        end else if (upd && !latched) begin
            alarm_next = alarm_reg & hold;
        end else if (!latched && !alarm_reg) begin
            alarm_next = 1'b0;
        end
    end // latched with no clear keeps the alarm

    // alarm state and its two outputs loaded together
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_reg <= 1'b0;
            relay_reg <= 1'b0;
            led_reg   <= 1'b0;
        end else begin
            alarm_reg <= alarm_next;
            relay_reg <= alarm_next;
            led_reg   <= alarm_next;
        end
    end

    assign alarm_relay = relay_reg;
    assign alarm_led   = led_reg;

    // last reading kept for software
    always_ff @(posedge clk) begin
        if (rst) begin
            last_reg <= '0;
        end else if (upd) begin
            last_reg <= rd;
        end
    end

    // bus decode: one wait cycle, then the access completes
    wire       req    = avs_read | avs_write;
    wire       go     = req & ~wait_reg;
    wire [2:0] widx   = avs_address[4:2];
    wire       hit_c  = (widx == OFF_CTRL[4:2]);
    wire       hit_s  = (widx == OFF_STAT[4:2]);
    wire       hit_p  = (widx == OFF_SETP[4:2]);
    wire       hit_r  = (widx == OFF_READ[4:2]);
    wire       hit_w  = (widx == OFF_SWCH[4:2]);
    wire       wr_c   = go & avs_write & hit_c & avs_byteenable[0];

    // read mux; unmapped words read zero
    logic [31:0] stat_w;
    logic [31:0] rmux;
    always_comb begin
        stat_w = '0;
        stat_w[STAT_ALARM_BIT] = alarm_reg;
        stat_w[STAT_SPON_BIT]  = sp_on;
        stat_w[STAT_TRIP_BIT]  = trip;
        stat_w[STAT_DIR_BIT]   = dir_hi;
        stat_w[STAT_LATCH_BIT] = latched;
        stat_w[STAT_XCLR_BIT]  = xclr;
        rmux = '0;
        if (hit_c) begin
            rmux[CTRL_EN_BIT] = en_reg;
        end else if (hit_s) begin
            rmux = stat_w;
        end else if (hit_p) begin
            rmux = 32'(signed'(sp));
        end else if (hit_r) begin
            rmux = 32'(signed'(last_reg));
        end else if (hit_w) begin
            rmux = 32'(sw);
        end
    end

    // handshake and control register
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_reg  <= 1'b1;
            rdata_reg <= '0;
            en_reg    <= CTRL_RESET[CTRL_EN_BIT];
            clr_reg   <= 1'b0;
        end else begin
            wait_reg  <= ~(req & wait_reg);
            rdata_reg <= (req & wait_reg & avs_read) ? rmux : rdata_reg;
            clr_reg   <= wr_c & avs_writedata[CTRL_CLR_BIT];
            if (wr_c) begin
                en_reg <= avs_writedata[CTRL_EN_BIT];
            end
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // helper: live conditions in the same cycle, not registered
    wire act = sp_on && en_reg && !xclr;

    AST_SP_RANGE: assert property (
        (sp <= SP_LIMIT) && (sp >= -SP_LIMIT))
        else $error("setpoint outside range");

    AST_SIGN_THOU: assert property (
        sw.thousands_sign_digit[THOU_NEG_BIT] && !sw.thousands_sign_digit[2]
        ##1 sw.thousands_sign_digit == $past(sw.thousands_sign_digit)
        |-> sp <= 0)
        else $error("negative thousands gave positive setpoint");

    AST_HIGH_TRIP: assert property (
        act && upd && dir_hi && rd >= sp |=> alarm_reg && alarm_relay)
        else $error("rising trip missed");

    AST_LOW_TRIP: assert property (
        act && upd && !dir_hi && rd <= sp |=> alarm_reg && alarm_led)
        else $error("falling trip missed");

    AST_EQUAL_TRIP: assert property (
        act && upd && rd == sp |=> alarm_relay)
        else $error("equal reading did not trip");

    AST_EXT_CLEAR: assert property (
        xclr |=> !alarm_relay && !alarm_led)
        else $error("alarm on while clear contact closed");

    AST_OFF_NONE: assert property (
        !sp_on |=> !alarm_reg)
        else $error("alarm with setpoint off");

    AST_OUT_PAIR: assert property (
        (alarm_relay == alarm_led) && (alarm_relay == alarm_reg))
        else $error("relay and indicator disagree");

    AST_LATCH_HOLD: assert property (
        alarm_reg && latched && act && !clr_reg |=> alarm_reg)
        else $error("latched alarm dropped");

    AST_AUTO_HOLD: assert property (
        alarm_reg && !latched && act && upd && hold |=> alarm_reg)
        else $error("alarm released inside deadband");

    AST_AUTO_FREE: assert property (
        alarm_reg && !latched && act && upd && !trip && !hold
        |=> !alarm_reg && !alarm_relay)
        else $error("self clearing alarm not released");

    AST_DB_ZERO: assert property (
        db == 4'h0 |-> ret_lim == sp)
        else $error("zero deadband moved the limit");

    AST_DB_MAX: assert property (
        db <= DB_MAX)
        else $error("deadband above nine");

    // clearing, strobe, return limit and enable checks
    AST_XCLR_FREE: assert property (
        alarm_reg && latched && xclr |=> !alarm_reg && !alarm_led)
        else $error("clear contact did not release latched alarm");

    AST_SW_CLEAR: assert property (
        clr_reg && latched && act && !upd |=> !alarm_reg)
        else $error("software clear ignored");

    AST_SET_WINS: assert property (
        act && upd && trip && clr_reg |=> alarm_reg)
        else $error("clear beat a trip");

    AST_NO_STROBE: assert property (
        !alarm_reg && !upd |=> !alarm_reg)
        else $error("alarm rose without a reading");

    AST_RD_KEEP: assert property (
        upd |=> last_reg == $past(rd))
        else $error("reading not kept");

    AST_RET_SIDE: assert property (
        dir_hi ? (ret_lim <= sp) : (ret_lim >= sp))
        else $error("return limit on the wrong side");

    AST_EN_OFF: assert property (
        !en_reg |=> !alarm_reg && !alarm_relay)
        else $error("alarm on while disabled");

    // bus handshake check
    AST_BUS_WAIT: assert property (
        req && wait_reg |=> !wait_reg ##1 wait_reg)
        else $error("bus answer not one cycle");

    // scenarios
    COV_HIGH_TRIP: cover property (act && dir_hi ##1 $rose(alarm_relay));
    COV_LOW_TRIP:  cover property (act && !dir_hi ##1 $rose(alarm_relay));
    COV_LATCH_CLR: cover property (alarm_reg && latched ##1 clr_reg
                                   ##1 !alarm_reg);
    COV_XCLR:      cover property (alarm_reg && xclr ##1 !alarm_reg);

endmodule

//--- alr_pkg.sv
// package: constants, carrier types and helpers for the alarm comparator
package alr_pkg;

    // value width used for readings, setpoints and limits
    localparam int VAL_W = 16;
    typedef logic signed [VAL_W-1:0] alr_val_t;

    // front and rear panel switches plus the clear contact, as sampled
    typedef struct packed {
        logic       trip_direction_switch;    // 1: rising trip, 0: falling
        logic [3:0] thousands_sign_digit;     // sign, thousands or off
        logic [3:0] hundreds_digit_switch;
        logic [3:0] tens_digit_switch;
        logic [3:0] units_digit_switch;
        logic [3:0] hysteresis_selector;      // deadband 0..9
        logic       reset_policy_switch;      // 1: latched, 0: self clear
        logic       external_clear_terminals; // 1: contact closed
    } alr_switch_t;

    localparam int SW_W = $bits(alr_switch_t);

    // switch level meanings
    localparam logic RISING_TRIP_DIRECTION  = 1'b1;
    localparam logic FALLING_TRIP_DIRECTION = 1'b0;
    localparam logic LATCHED_POLICY         = 1'b1;

    // thousands switch: bit 3 sign, bits 1:0 thousands, bit 2 set is off
    localparam int       THOU_NEG_BIT = 3;
    localparam int       THOU_OFF_BIT = 2;
    localparam logic [3:0] THOU_OFF_CODE = 4'hf;
    localparam logic [3:0] DIGIT_MAX     = 4'h9;
    localparam logic [3:0] DB_MAX        = 4'h9;
    localparam alr_val_t   SP_LIMIT      = 16'h0f9f; // 3999

    // register byte offsets on the avalon slave
    localparam logic [4:0] OFF_CTRL  = 5'h00;
    localparam logic [4:0] OFF_STAT  = 5'h04;
    localparam logic [4:0] OFF_SETP  = 5'h08;
    localparam logic [4:0] OFF_READ  = 5'h0c;
    localparam logic [4:0] OFF_SWCH  = 5'h10;

    // control register fields and reset value
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_CLR_BIT = 1;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0001;

    // status register fields
    localparam int STAT_ALARM_BIT = 0;
    localparam int STAT_SPON_BIT  = 1;
    localparam int STAT_TRIP_BIT  = 2;
    localparam int STAT_DIR_BIT   = 3;
    localparam int STAT_LATCH_BIT = 4;
    localparam int STAT_XCLR_BIT  = 5;

    // digit check used for the hundreds, tens and units switches
    function automatic logic alr_digit_ok(input logic [3:0] d);
        return d <= DIGIT_MAX;
    endfunction

    // widen a 4-bit count into the value type
    function automatic alr_val_t alr_widen(input logic [3:0] d);
        return alr_val_t'({12'h000, d});
    endfunction

endpackage

//--- alr_sync.sv
// synchroniser for panel switches and the clear contact
`timescale 1ns/1ps
module alr_sync
    import alr_pkg::*;
#(
    parameter int W = SW_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // raw pins and filtered result
    input  wire logic [W-1:0] pin_raw,
    output logic      [W-1:0] pin_stable
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] stable_reg;
    logic [W-1:0] stable_next;
    wire  [W-1:0] agree;

    // a bit changes only where the second and third stages agree
    assign agree       = ~(s2_reg ^ s3_reg);
    assign stable_next = (s3_reg & agree) | (stable_reg & ~agree);
    assign pin_stable  = stable_reg;

    // three stage chain; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg     <= '0;
            s2_reg     <= '0;
            s3_reg     <= '0;
            stable_reg <= '0;
        end else begin
            s1_reg     <= pin_raw;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            stable_reg <= stable_next;
        end
    end

endmodule

//--- alr_setpoint.sv
// decodes the digit switches into a signed setpoint and a deadband
`timescale 1ns/1ps
module alr_setpoint
    import alr_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // synchronised switches
    input  wire alr_switch_t sw,
    // decoded settings
    output alr_val_t         sp_value,
    output logic             sp_on,
    output logic [3:0]       deadband
);

    alr_val_t   sp_reg;
    logic       on_reg;
    logic [3:0] db_reg;
    wire  [3:0] th;
    wire        th_ok;
    wire        digits_ok;
    wire        sp_ok;
    alr_val_t   mag;

    assign th = sw.thousands_sign_digit;
    // off position (or any code outside the sign range) disables
    assign th_ok     = ~th[THOU_OFF_BIT] && (th != THOU_OFF_CODE);
    assign digits_ok = alr_digit_ok(sw.hundreds_digit_switch)
                     & alr_digit_ok(sw.tens_digit_switch)
                     & alr_digit_ok(sw.units_digit_switch);
    // a disabled setpoint reads zero so the range stays within four digits
    assign sp_ok     = th_ok & digits_ok;

    // thousands, hundreds, tens, units weighting
    assign mag = alr_val_t'(alr_widen({2'b00, th[1:0]}) * 16'sd1000
               + alr_widen(sw.hundreds_digit_switch) * 16'sd100
               + alr_widen(sw.tens_digit_switch) * 16'sd10
               + alr_widen(sw.units_digit_switch));

    assign sp_value = sp_reg;
    assign sp_on    = on_reg;
    assign deadband = db_reg;

    // registered so a switch change applies from the next comparison
    always_ff @(posedge clk) begin
        if (rst) begin
            sp_reg <= '0;
            on_reg <= 1'b0;
            db_reg <= '0;
        end else begin
            sp_reg <= sp_ok ? (th[THOU_NEG_BIT] ? -mag : mag) : '0;
            on_reg <= sp_ok;
            db_reg <= (sw.hysteresis_selector > DB_MAX) ? DB_MAX
                                                       : sw.hysteresis_selector;
        end
    end

endmodule

//--- alr_far_side.sv
// far side model: converter readings and the external clear contact
`timescale 1ns/1ps
module alr_far_side
    import alr_pkg::*;
#(
    parameter int RD_W = 14
) (
    // clock
    input  wire logic       clk,
    // reading strobe and value
    output logic            rd_valid,
    output logic [RD_W-1:0] rd_data,
    // clear contact, high while closed
    output logic            clr_closed
);
    // idle levels at time zero
    initial begin
        rd_valid   = 1'b0;
        rd_data    = '0;
        clr_closed = 1'b0;
    end

    // one strobe per reading; the value is scrambled once released
    task automatic send(input logic [RD_W-1:0] v);
        @(posedge clk);
        rd_valid <= 1'b1;
        rd_data  <= v;
        @(posedge clk);
        rd_valid <= 1'b0;
        rd_data  <= ~v;   // stale value must not be relied on
    endtask

    // normally open contact, closed by a level of one
    task automatic contact(input logic lvl);
        @(posedge clk);
        clr_closed <= lvl;
    endtask
endmodule

//--- alr_comparator_bench.sv
// self-checking bench for the alarm setpoint comparator
`timescale 1ns/1ps
module alr_comparator_bench;
    import alr_pkg::*;
    logic        clk;
    logic        rst;
    logic        rd_valid;
    logic [13:0] rd_data;
    logic        clr_closed;
    alr_switch_t panel;
    alr_switch_t sw_pins;
    logic        alarm_relay;
    logic        alarm_led;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [3:0]  avs_byteenable;
    logic [3:0]  be;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [31:0] rdat;
    int          bad_count;
    int          tests_run;
    int          sgn;
    int          offs[4] = '{1, 0, 6, 7};
    logic        expv[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    // clock at 100 MHz
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // panel switches with the clear contact from the far side
    always_comb begin
        sw_pins = panel;
        sw_pins.external_clear_terminals = clr_closed;
    end

    alr_far_side far (
        .clk        (clk),
        .rd_valid   (rd_valid),
        .rd_data    (rd_data),
        .clr_closed (clr_closed)
    );

    alr_comparator dut (
        .clk             (clk),
        .rst             (rst),
        .rd_valid        (rd_valid),
        .rd_data         (rd_data),
        .sw_pins         (sw_pins),
        .alarm_relay     (alarm_relay),
        .alarm_led       (alarm_led),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_byteenable  (avs_byteenable),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest)
    );

    // compare and count
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_address   <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rdat = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) check("waitrequest", 32'h1, 32'h0);
    endtask

    // both alarm outputs against one expectation
    task automatic ck_alarm(input logic exp);
        check("alarm_relay", {31'h0, alarm_relay}, {31'h0, exp});
        check("alarm_led", {31'h0, alarm_led}, {31'h0, exp});
    endtask

    // send a reading and look at the alarm one cycle later
    task automatic hit(input int v, input logic exp);
        far.send(14'(v));
        #1;
        ck_alarm(exp);
    endtask

    // new panel setting, then wait out the synchroniser
    task automatic setsw(input logic dir, input logic [3:0] th, h, t, u, db,
                         input logic lat);
        @(posedge clk);
        panel.trip_direction_switch <= dir;
        panel.thousands_sign_digit  <= th;
        panel.hundreds_digit_switch <= h;
        panel.tens_digit_switch     <= t;
        panel.units_digit_switch    <= u;
        panel.hysteresis_selector   <= db;
        panel.reset_policy_switch   <= lat;
        repeat (8) @(posedge clk);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        bad_count = 0;
        tests_run = 0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hf;
        be = 4'hf;
        panel = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        ck_alarm(1'b0);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl reset", rdat, CTRL_RESET);
        bus(1'b0, 5'h14, 32'h0);
        check("unmapped", rdat, 32'h0);
        // rising +1000, no deadband
        setsw(RISING_TRIP_DIRECTION, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
        bus(1'b0, OFF_SETP, 32'h0);
        check("setpoint", rdat, 32'h0000_03e8);
        hit(999, 1'b0);
        hit(1000, 1'b1);
        hit(999, 1'b0);
        // falling -3999
        setsw(FALLING_TRIP_DIRECTION, 4'hb, 4'h9, 4'h9, 4'h9, 4'h0, 1'b0);
        bus(1'b0, OFF_SETP, 32'h0);
        check("setpoint", rdat, 32'hffff_f061);
        bus(1'b0, OFF_STAT, 32'h0);
        check("dir", {31'h0, rdat[STAT_DIR_BIT]}, 32'h0);
        hit(-3998, 1'b0);
        hit(-3999, 1'b1);
        hit(-3998, 1'b0);
        // deadband 6 around +100, both directions
        for (int d = 0; d < 2; d++) begin
            setsw(d == 0, 4'h0, 4'h1, 4'h0, 4'h0, 4'h6, 1'b0);
            sgn = (d == 0) ? -1 : 1;
            foreach (offs[i]) hit(100 + sgn * offs[i], expv[i]);
        end
        // latched +100
        setsw(RISING_TRIP_DIRECTION, 4'h0, 4'h1, 4'h0, 4'h0, 4'h0, 1'b1);
        hit(100, 1'b1);
        hit(50, 1'b1);
        far.contact(1'b1);
        repeat (6) @(posedge clk);
        far.contact(1'b0);
        repeat (6) @(posedge clk);
        #1;
        ck_alarm(1'b0);
        far.contact(1'b1);
        repeat (6) @(posedge clk);
        hit(200, 1'b0);
        far.contact(1'b0);
        repeat (6) @(posedge clk);
        hit(200, 1'b1);
        bus(1'b1, OFF_CTRL, 32'h3);
        @(posedge clk);
        #1;
        ck_alarm(1'b0);
        be = 4'he;
        bus(1'b1, OFF_CTRL, 32'h0);
        be = 4'hf;
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl lane", rdat, 32'h1);
        bus(1'b1, OFF_CTRL, 32'h0);
        hit(200, 1'b0);
        bus(1'b1, OFF_CTRL, 32'h1);
        bus(1'b1, OFF_SETP, 32'h0);
        bus(1'b0, OFF_SETP, 32'h0);
        check("setpoint ro", rdat, 32'h0000_0064);
        // thousands switch off
        setsw(RISING_TRIP_DIRECTION, THOU_OFF_CODE, 4'h0, 4'h0, 4'h0, 4'h0,
              1'b0);
        hit(3000, 1'b0);
        bus(1'b0, OFF_STAT, 32'h0);
        check("sp on", {31'h0, rdat[STAT_SPON_BIT]}, 32'h0);
        // mid-run reset brings the enable back
        bus(1'b1, OFF_CTRL, 32'h0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        ck_alarm(1'b0);
        bus(1'b0, OFF_CTRL, 32'h0);
        check("ctrl after reset", rdat, CTRL_RESET);
        summarize();
    end

    // hang guard, far beyond the expected run
    initial begin
        #500000;
        bad_count++;
        summarize();
    end
endmodule
